// File: core/sag_pkg.sv
package sag_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int PA_W   = 20;
   localparam int OFS_W  = 16;
   localparam int SEG_SH = 4;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] SP_RST    = 16'h0000;
   localparam logic [15:0] IDX_RST   = 16'h0000;

   // ****************************************
   // reference kinds and segment selects
   // ****************************************
   typedef enum logic [2:0] {
      SAG_REF_FETCH = 3'h0,
      SAG_REF_STACK = 3'h1,
      SAG_REF_VAR   = 3'h2,
      SAG_REF_SRC   = 3'h3,
      SAG_REF_DST   = 3'h4,
      SAG_REF_BP    = 3'h5
   } sag_ref_t;

   typedef enum logic [1:0] {
      SAG_SEG_EXTRA = 2'h0,
      SAG_SEG_CODE  = 2'h1,
      SAG_SEG_STACK = 2'h2,
      SAG_SEG_DATA  = 2'h3
   } sag_seg_t;

   typedef enum logic [4:0] {
      SAG_ST_IDLE  = 5'h01,
      SAG_ST_LO    = 5'h02,
      SAG_ST_HI    = 5'h04,
      SAG_ST_WAIT  = 5'h08,
      SAG_ST_POST  = 5'h10
   } sag_state_t;
endpackage : sag_pkg

// File: core/sag_seg_select.sv
`timescale 1ns/100ps
`default_nettype none
module sag_seg_select
   import sag_pkg::*;
(
   input  wire sag_pkg::sag_ref_t ref_kind,
   input  wire logic              ovr_valid,
   input  wire sag_pkg::sag_seg_t ovr_seg,
   output sag_pkg::sag_seg_t      seg_sel
);
   always_comb begin
      seg_sel = SAG_SEG_DATA;
      unique case (ref_kind)
         SAG_REF_FETCH: seg_sel = SAG_SEG_CODE;
         SAG_REF_STACK: seg_sel = SAG_SEG_STACK;
         SAG_REF_DST:   seg_sel = SAG_SEG_EXTRA;
         SAG_REF_BP:    seg_sel = ovr_valid ? ovr_seg : SAG_SEG_STACK;
         SAG_REF_SRC:   seg_sel = ovr_valid ? ovr_seg : SAG_SEG_DATA;
         default:       seg_sel = ovr_valid ? ovr_seg : SAG_SEG_DATA;
      endcase
   end
endmodule : sag_seg_select
`default_nettype wire

// File: core/sag_phys_add.sv
`timescale 1ns/100ps
`default_nettype none
module sag_phys_add
   import sag_pkg::*;
(
   input  wire logic [15:0] seg_base,
   input  wire logic [15:0] offset,
   output logic [19:0]      phys
);
   // unsigned, base shifted four places; carry out of bit 19 is dropped
   logic [19:0] base_wide;
   assign base_wide = {4'h0, seg_base} << SEG_SH;
   assign phys = base_wide + {4'h0, offset};
endmodule : sag_phys_add
`default_nettype wire

// File: core/sag_agen.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - 20-bit physical address on every memory access
// - segment and offset are unsigned 16-bit
// - address is base shifted four plus offset
// - offset stepping wraps within 64k segment
// - fetches use code segment, no override
// - stack uses stack segment, no override
// - variables default data segment, overridable
// - string source default data, overridable
// - string destination always extra segment
// - base pointer references default stack segment
// - override prefix applies to next instruction
// - string indices step one or two
// - stack is word wide
// - push decrements by two then writes
// - pop reads then increments by two
// - stack items never moved or erased
// - wide bus: even word one cycle
// - wide bus fetch words, odd target byte
// - narrow bus: every access one byte
// - direction flag set means decrement
// - low byte at lower address
module sag_agen
   import sag_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              bus_is_narrow,
   input  wire logic [15:0]       code_segment_base,
   input  wire logic [15:0]       stack_segment_base,
   input  wire logic [15:0]       data_segment_base,
   input  wire logic [15:0]       extra_segment_base,
   input  wire logic [15:0]       instruction_pointer,
   input  wire logic [15:0]       effective_address,
   input  wire logic              req_valid,
   input  wire sag_pkg::sag_ref_t req_kind,
   input  wire logic              req_write,
   input  wire logic              req_word,
   input  wire logic              req_after_jump,
   input  wire logic [15:0]       req_wdata,
   input  wire logic              ovr_set,
   input  wire sag_pkg::sag_seg_t ovr_seg_in,
   input  wire logic              insn_end,
   input  wire logic              direction_flag,
   input  wire logic              sp_load,
   input  wire logic [15:0]       sp_load_val,
   input  wire logic              idx_load,
   input  wire logic [15:0]       src_index_load,
   input  wire logic [15:0]       dst_index_load,
   input  wire logic              mem_ready,
   input  wire logic [15:0]       mem_rdata,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [15:0]            rsp_rdata,
   output logic                   mem_valid,
   output logic [19:0]            mem_addr,
   output logic                   mem_write,
   output logic                   mem_lo_en,
   output logic                   mem_hi_en,
   output logic [15:0]            mem_wdata,
   output logic [15:0]            stack_pointer,
   output logic [15:0]            source_index,
   output logic [15:0]            destination_index
);
   import sag_pkg::*;

   // ****************************************
   // request capture and segment choice
   // ****************************************
   sag_state_t  st_r;
   sag_ref_t    kind_r;
   sag_seg_t    seg_sel;
   logic        ovr_valid_r;
   sag_seg_t    ovr_seg_r;
   logic        write_r;
   logic        word_r;
   logic        split_r;
   logic [15:0] ofs_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic [15:0] seg_base;
   logic [15:0] cur_ofs;
   logic [19:0] phys;
   logic [15:0] sp_r;
   logic [15:0] si_r;
   logic [15:0] di_r;
   logic [15:0] req_ofs;
   logic        take;

   assign take = req_valid && req_ready;

   // prefix held until the instruction it modifies finishes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovr_valid_r <= 1'b0;
         ovr_seg_r   <= SAG_SEG_DATA;
      end else if (ovr_set) begin
         ovr_valid_r <= 1'b1;
         ovr_seg_r   <= ovr_seg_in;
      end else if (insn_end) begin
         ovr_valid_r <= 1'b0;
      end
   end

   sag_seg_select u_sel (
      .ref_kind  (kind_r),
      .ovr_valid (ovr_valid_r),
      .ovr_seg   (ovr_seg_r),
      .seg_sel   (seg_sel)
   );

   always_comb begin
      seg_base = data_segment_base;
      unique case (seg_sel)
         SAG_SEG_CODE:  seg_base = code_segment_base;
         SAG_SEG_STACK: seg_base = stack_segment_base;
         SAG_SEG_EXTRA: seg_base = extra_segment_base;
         SAG_SEG_DATA:  seg_base = data_segment_base;
      endcase
   end

   // push addresses the slot below the current top
   always_comb begin
      req_ofs = effective_address;
      unique case (req_kind)
         SAG_REF_FETCH: req_ofs = instruction_pointer;
         SAG_REF_STACK: req_ofs = req_write ? (sp_r - STEP_WORD) : sp_r;
         SAG_REF_SRC:   req_ofs = si_r;
         SAG_REF_DST:   req_ofs = di_r;
         default:       req_ofs = effective_address;
      endcase
   end

   // second byte uses offset plus one, wrapped in 16 bits
   assign cur_ofs = (st_r == SAG_ST_HI) ? ofs_r + STEP_BYTE : ofs_r;

   sag_phys_add u_add (
      .seg_base (seg_base),
      .offset   (cur_ofs),
      .phys     (phys)
   );

   // ****************************************
   // bus cycle sequencer
   // ****************************************
   logic lo_en_nxt;
   logic hi_en_nxt;
   logic odd_ofs;
   assign odd_ofs = cur_ofs[0];

   // byte lanes: wide bus picks the lane by address parity
   always_comb begin
      lo_en_nxt = 1'b1;
      hi_en_nxt = 1'b0;
      if (bus_is_narrow) begin
         lo_en_nxt = 1'b1;
         hi_en_nxt = 1'b0;
      end else if (word_r && !split_r) begin
         lo_en_nxt = 1'b1;
         hi_en_nxt = 1'b1;
      end else begin
         lo_en_nxt = !odd_ofs;
         hi_en_nxt = odd_ofs;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r    <= SAG_ST_IDLE;
         kind_r  <= SAG_REF_VAR;
         write_r <= 1'b0;
         word_r  <= 1'b0;
         split_r <= 1'b0;
         ofs_r   <= IDX_RST;
         wdata_r <= 16'h0000;
      end else begin
         unique case (st_r)
            SAG_ST_IDLE: begin
               if (take) begin
                  kind_r  <= req_kind;
                  write_r <= req_write;
                  // stack items are always whole words
                  word_r  <= req_word || (req_kind == SAG_REF_STACK);
                  // fetch after jump to odd address is a single byte;
                  // narrow bus fetches one byte per request
                  if (req_kind == SAG_REF_FETCH) begin
                     word_r <= !bus_is_narrow && !(req_after_jump && req_ofs[0]);
                  end
                  ofs_r   <= req_ofs;
                  wdata_r <= req_wdata;
                  split_r <= bus_is_narrow || req_ofs[0];
                  st_r    <= SAG_ST_LO;
               end
            end
            SAG_ST_LO: begin
               if (mem_ready) begin
                  st_r <= (word_r && split_r) ? SAG_ST_HI : SAG_ST_POST;
               end
            end
            SAG_ST_HI: begin
               if (mem_ready) begin
                  st_r <= SAG_ST_POST;
               end
            end
            SAG_ST_POST: st_r <= SAG_ST_IDLE;
            default:     st_r <= SAG_ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // bus outputs, registered
   // ****************************************
   logic in_cycle;
   assign in_cycle = (st_r == SAG_ST_LO) || (st_r == SAG_ST_HI);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_valid <= 1'b0;
         mem_addr  <= 20'h00000;
         mem_write <= 1'b0;
         mem_lo_en <= 1'b0;
         mem_hi_en <= 1'b0;
         mem_wdata <= 16'h0000;
      end else begin
         mem_valid <= in_cycle && !(mem_valid && mem_ready);
         mem_addr  <= phys;
         mem_write <= write_r && in_cycle;
         mem_lo_en <= lo_en_nxt && in_cycle;
         mem_hi_en <= hi_en_nxt && in_cycle;
         // low byte to the lower address; narrow split sends high next
         if (st_r == SAG_ST_HI) begin
            mem_wdata <= {wdata_r[15:8], wdata_r[15:8]};
         end else if (split_r) begin
            mem_wdata <= {wdata_r[7:0], wdata_r[7:0]};
         end else begin
            mem_wdata <= wdata_r;
         end
      end
   end

   // collect read data: lower address byte is the low half
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_r <= 16'h0000;
      end else if (mem_valid && mem_ready && !mem_write) begin
         if (mem_lo_en && mem_hi_en) begin
            rdata_r <= mem_rdata;
         end else if (st_r == SAG_ST_HI || (st_r == SAG_ST_POST && word_r && split_r)) begin
            rdata_r[15:8] <= mem_hi_en ? mem_rdata[15:8] : mem_rdata[7:0];
         end else begin
            rdata_r[7:0]  <= mem_hi_en ? mem_rdata[15:8] : mem_rdata[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
      end else begin
         req_ready <= (st_r == SAG_ST_IDLE) && !take;
         rsp_valid <= (st_r == SAG_ST_POST);
         rsp_rdata <= rdata_r;
      end
   end

   // ****************************************
   // pointer and index updates
   // ****************************************
   logic [15:0] str_step;
   assign str_step = word_r ? STEP_WORD : STEP_BYTE;

   // stack memory is never touched besides the addressed word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sp_r <= SP_RST;
      end else if (sp_load) begin
         sp_r <= sp_load_val;
      end else if (st_r == SAG_ST_POST && kind_r == SAG_REF_STACK) begin
         sp_r <= write_r ? ofs_r : sp_r + STEP_WORD;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         si_r <= IDX_RST;
         di_r <= IDX_RST;
      end else if (idx_load) begin
         si_r <= src_index_load;
         di_r <= dst_index_load;
      end else if (st_r == SAG_ST_POST) begin
         if (kind_r == SAG_REF_SRC) begin
            si_r <= direction_flag ? si_r - str_step : si_r + str_step;
         end
         if (kind_r == SAG_REF_DST) begin
            di_r <= direction_flag ? di_r - str_step : di_r + str_step;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stack_pointer     <= SP_RST;
         source_index      <= IDX_RST;
         destination_index <= IDX_RST;
      end else begin
         stack_pointer     <= sp_r;
         source_index      <= si_r;
         destination_index <= di_r;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_fetch_code_seg: assert property (@(posedge ref_clk) disable iff (rst)
      (kind_r == SAG_REF_FETCH) |-> (seg_sel == SAG_SEG_CODE))
      else $error("fetch not using code segment");
   a_dst_extra_seg: assert property (@(posedge ref_clk) disable iff (rst)
      (kind_r == SAG_REF_DST) |-> (seg_sel == SAG_SEG_EXTRA))
      else $error("string destination not extra segment");
   a_stack_seg: assert property (@(posedge ref_clk) disable iff (rst)
      (kind_r == SAG_REF_STACK) |-> (seg_sel == SAG_SEG_STACK))
      else $error("stack not stack segment");
   a_phys_calc: assert property (@(posedge ref_clk) disable iff (rst)
      in_cycle |=> (mem_addr == (({4'h0, $past(seg_base)} << SEG_SH) + {4'h0, $past(cur_ofs)})))
      else $error("physical address mismatch");
   a_push_sp_dec: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == SAG_ST_POST && kind_r == SAG_REF_STACK && write_r && !sp_load)
      |=> (sp_r == $past(sp_r) - STEP_WORD))
      else $error("push did not lower pointer by two");
   a_pop_sp_inc: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == SAG_ST_POST && kind_r == SAG_REF_STACK && !write_r && !sp_load)
      |=> (sp_r == $past(sp_r) + STEP_WORD))
      else $error("pop did not raise pointer by two");
   a_narrow_byte: assert property (@(posedge ref_clk) disable iff (rst)
      (mem_valid && bus_is_narrow) |-> !(mem_lo_en && mem_hi_en))
      else $error("narrow bus word access");
   a_split_next: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == SAG_ST_LO && mem_ready && word_r && split_r) |=> (cur_ofs == ofs_r + STEP_BYTE))
      else $error("second byte address wrong");
endmodule : sag_agen
`default_nettype wire

// File: verification/sag_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module sag_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        bus_is_narrow,
   input  wire logic [3:0]  mem_lat,
   input  wire logic        mem_valid,
   input  wire logic [19:0] mem_addr,
   input  wire logic        mem_write,
   input  wire logic        mem_lo_en,
   input  wire logic        mem_hi_en,
   input  wire logic [15:0] mem_wdata,
   output logic             mem_ready,
   output logic [15:0]      mem_rdata
);
   logic [7:0]  mem [logic [19:0]];
   logic [3:0]  cnt_r = 4'h0;
   logic [19:0] lo_a;
   logic [19:0] hi_a;

   function automatic logic [7:0] rd(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction : rd

   // narrow bus carries every byte on the low lane
   assign lo_a = bus_is_narrow ? mem_addr : {mem_addr[19:1], 1'b0};
   assign hi_a = {mem_addr[19:1], 1'b1};

   initial begin
      mem_ready = 1'b0;
      mem_rdata = 16'h0000;
   end

   always @(posedge ref_clk) begin
      // undriven data toggles so a stale read never matches by luck
      mem_rdata <= ~mem_rdata;
      if (mem_ready) begin
         mem_ready <= 1'b0;
         cnt_r <= 4'h0;
         if (mem_valid && mem_write && mem_lo_en) begin
            mem[lo_a] = mem_wdata[7:0];
         end
         if (mem_valid && mem_write && mem_hi_en && !bus_is_narrow) begin
            mem[hi_a] = mem_wdata[15:8];
         end
      end else if (mem_valid) begin
         if (cnt_r >= mem_lat) begin
            mem_ready <= 1'b1;
            mem_rdata <= {rd(hi_a), rd(lo_a)};
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule : sag_mem_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import sag_pkg::*;
   logic        ref_clk = 1'b0, rst = 1'b1, bus_is_narrow = 1'b0, req_valid = 1'b0;
   logic        req_write = 1'b0, req_word = 1'b0, req_after_jump = 1'b0, ovr_set = 1'b0;
   logic        insn_end = 1'b0, direction_flag = 1'b0, sp_load = 1'b0, idx_load = 1'b0;
   logic        mem_ready, req_ready, rsp_valid, mem_valid, mem_write, mem_lo_en, mem_hi_en;
   logic [15:0] req_wdata = 16'h0000, sp_load_val = 16'h0000, src_index_load = 16'h0000;
   logic [15:0] dst_index_load = 16'h0000, instruction_pointer = 16'h0000;
   logic [15:0] effective_address = 16'h0000, segs [4] = '{16'h2340, 16'h1230, 16'h3450, 16'h4560};
   logic [15:0] code_segment_base, stack_segment_base, data_segment_base, extra_segment_base;
   logic [15:0] mem_rdata, rsp_rdata, mem_wdata, stack_pointer, source_index, destination_index;
   logic [15:0] rd_got, si_e, di_e;
   logic [19:0] mem_addr, ba_q[$];
   logic [1:0]  ln_q[$];
   logic [3:0]  mem_lat = 4'h0;
   sag_ref_t    req_kind = SAG_REF_FETCH;
   sag_seg_t    ovr_seg_in = SAG_SEG_EXTRA;
   int          fail_count = 0, n_compared = 0, cyc = 0;

   assign extra_segment_base = segs[0];
   assign code_segment_base  = segs[1];
   assign stack_segment_base = segs[2];
   assign data_segment_base  = segs[3];

   sag_agen i_sag_agen (.*);
   sag_mem_model i_sag_mem_model (.*);

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // byte address of each finished bus cycle, lane pair beside it
   always @(posedge ref_clk) begin
      if (mem_valid && mem_ready) begin
         ba_q.push_back(bus_is_narrow ? mem_addr : {mem_addr[19:1], mem_hi_en & ~mem_lo_en});
         ln_q.push_back({mem_hi_en, mem_lo_en});
      end
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [19:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic do_reset(input logic nb);
      @(negedge ref_clk);
      rst = 1'b1;
      bus_is_narrow = nb;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
   endtask : do_reset

   task automatic do_req(input sag_ref_t k, input logic w, wd, aj, input logic [15:0] d);
      int n;
      n = 0;
      ba_q.delete();
      ln_q.delete();
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_kind = k;
      req_write = w;
      req_word = wd;
      req_after_jump = aj;
      req_wdata = d;
      @(posedge ref_clk);
      while (req_ready !== 1'b1 && n < 200) begin
         n++;
         @(posedge ref_clk);
      end
      @(negedge ref_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         n++;
         @(negedge ref_clk);
      end
      rd_got = rsp_rdata;
      chk(20'(n >= 400), 20'h0);
      repeat (2) @(negedge ref_clk);
   endtask : do_req

   task automatic pulse_ovr(input int o);
      @(negedge ref_clk);
      ovr_set = 1'b1;
      ovr_seg_in = sag_seg_t'(o);
      @(negedge ref_clk);
      ovr_set = 1'b0;
   endtask : pulse_ovr

   task automatic pulse_end;
      @(negedge ref_clk);
      insn_end = 1'b1;
      @(negedge ref_clk);
      insn_end = 1'b0;
   endtask : pulse_end

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_segments;
      logic [15:0] b;
      logic [15:0] off;
      instruction_pointer = 16'h0010;
      effective_address = 16'h0020;
      @(negedge ref_clk);
      idx_load = 1'b1;
      src_index_load = 16'h0100;
      dst_index_load = 16'h0200;
      @(negedge ref_clk);
      idx_load = 1'b0;
      si_e = 16'h0100;
      di_e = 16'h0200;
      // override index 4 means no prefix at all
      for (int o = 0; o < 5; o++) begin
         for (int k = 0; k < 6; k++) begin
            if (k != 1) begin
               if (o < 4) pulse_ovr(o);
               b = (k == 0) ? segs[1] : (k == 4) ? segs[0] : (o < 4) ? segs[o] :
                   (k == 5) ? segs[2] : segs[3];
               off = (k == 0) ? instruction_pointer : (k == 3) ? si_e :
                     (k == 4) ? di_e : effective_address;
               do_req(sag_ref_t'(k), k == 4, 1'b1, 1'b0, 16'h1234);
               chk(20'(ba_q.size()), 20'h1);
               chk(ba_q[0], {b, 4'h0} + {4'h0, off});
               if (k == 3) si_e += 16'h2;
               if (k == 4) di_e += 16'h2;
               pulse_end();
            end
         end
      end
      chk({4'h0, source_index}, {4'h0, si_e});
      chk({4'h0, destination_index}, {4'h0, di_e});
      direction_flag = 1'b1;
      do_req(SAG_REF_SRC, 1'b0, 1'b1, 1'b0, 16'h0000);
      do_req(SAG_REF_DST, 1'b1, 1'b0, 1'b0, 16'h0077);
      chk({4'h0, source_index}, {4'h0, si_e - 16'h2});
      chk({4'h0, destination_index}, {4'h0, di_e - 16'h1});
      direction_flag = 1'b0;
      $display("segments test done");
   endtask : t_segments

   task automatic t_wrap;
      segs[3] = 16'hF000;
      effective_address = 16'hFFFF;
      do_req(SAG_REF_VAR, 1'b1, 1'b1, 1'b0, 16'hBEEF);
      chk(20'(ba_q.size()), 20'h2);
      chk(ba_q[0], 20'hFFFFF);
      chk(ba_q[1], 20'hF0000);
      chk({12'h0, i_sag_mem_model.mem[20'hFFFFF]}, 20'h000EF);
      do_req(SAG_REF_VAR, 1'b0, 1'b1, 1'b0, 16'h0000);
      chk({4'h0, rd_got}, 20'h0BEEF);
      segs[3] = 16'h4560;
      $display("wrap test done");
   endtask : t_wrap

   task automatic stk(input logic w, input logic [15:0] d, at, sp_after);
      do_req(SAG_REF_STACK, w, 1'b1, 1'b0, d);
      chk(ba_q[0], {segs[2], 4'h0} + {4'h0, at});
      chk({4'h0, stack_pointer}, {4'h0, sp_after});
      if (!w) chk({4'h0, rd_got}, {4'h0, d});
   endtask : stk

   task automatic t_stack;
      mem_lat = 4'h3;
      @(negedge ref_clk);
      sp_load = 1'b1;
      sp_load_val = 16'h0002;
      @(negedge ref_clk);
      sp_load = 1'b0;
      // a pending prefix must not steer stack traffic
      pulse_ovr(1);
      stk(1'b1, 16'hA1B2, 16'h0000, 16'h0000);
      stk(1'b1, 16'hC3D4, 16'hFFFE, 16'hFFFE);
      stk(1'b0, 16'hC3D4, 16'hFFFE, 16'h0000);
      stk(1'b0, 16'hA1B2, 16'h0000, 16'h0002);
      pulse_end();
      $display("stack test done");
   endtask : t_stack

   task automatic t_jump;
      instruction_pointer = 16'h0011;
      do_req(SAG_REF_FETCH, 1'b0, 1'b1, 1'b1, 16'h0000);
      chk(20'(ba_q.size()), 20'h1);
      chk(ba_q[0], {segs[1], 4'h0} + 20'h00011);
      chk({18'h0, ln_q[0]}, 20'h2);
      instruction_pointer = 16'h0012;
      do_req(SAG_REF_FETCH, 1'b0, 1'b1, 1'b0, 16'h0000);
      chk({18'h0, ln_q[0]}, 20'h3);
      $display("jump test done");
   endtask : t_jump

   task automatic t_narrow;
      do_reset(1'b1);
      effective_address = 16'h0031;
      do_req(SAG_REF_VAR, 1'b1, 1'b1, 1'b0, 16'h5AC3);
      chk(20'(ba_q.size()), 20'h2);
      chk(ba_q[1], {segs[3], 4'h0} + 20'h00032);
      chk({18'h0, ln_q[1]}, 20'h1);
      effective_address = 16'h0030;
      do_req(SAG_REF_VAR, 1'b0, 1'b1, 1'b0, 16'h0000);
      chk(20'(ba_q.size()), 20'h2);
      chk({4'h0, rd_got}, 20'h0C300);
      do_req(SAG_REF_FETCH, 1'b0, 1'b1, 1'b0, 16'h0000);
      chk(20'(ba_q.size()), 20'h1);
      do_reset(1'b0);
      $display("narrow test done");
   endtask : t_narrow

   initial begin
      do_reset(1'b0);
      t_segments();
      t_wrap();
      t_stack();
      t_jump();
      t_narrow();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
